// file: scpc_pkg.sv
// Constants, field layouts and codes shared by the system clock and PLL configuration block.
package scpc_pkg;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam int          APB_AW              = 8;
  localparam logic [7:0]  OFS_CLOCK_DIVISOR   = 8'h00;
  localparam logic [7:0]  OFS_PLL_FEEDBACK    = 8'h04;
  localparam logic [7:0]  OFS_OSC_CONTROL     = 8'h08;
  localparam logic [7:0]  OFS_FACTOR_STATUS   = 8'h0C;
  localparam int          FRCPS_LSB           = 8;
  localparam int          POST_LSB            = 6;
  localparam int          PRE_LSB             = 0;
  localparam int          FBD_LSB             = 0;
  localparam int          CUR_SRC_LSB         = 12;
  localparam int          PRI_MODE_LSB        = 0;
  localparam int          CLK_MODE_LSB        = 4;
  localparam int          N1_LSB              = 0;
  localparam int          N2_LSB              = 8;
  localparam int          M_LSB               = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0]  FRCPS_RST           = 3'h0;
  localparam logic [1:0]  POST_RST            = 2'h1;
  localparam logic [4:0]  PRE_RST             = 5'h00;
  localparam logic [8:0]  FBD_RST             = 9'h030;

  // ****************************************
  // Divider codes and factors
  // ****************************************
  localparam logic [2:0]  FRCPS_MAX_CODE      = 3'h7;
  localparam logic [8:0]  FRC_DIV_MAX         = 9'h100;
  localparam logic [8:0]  FRC_DIV_ONE         = 9'h001;
  localparam logic [8:0]  FRC16_DIV           = 9'h010;
  localparam logic [1:0]  POST_DIV2           = 2'h0;
  localparam logic [1:0]  POST_DIV4           = 2'h1;
  localparam logic [1:0]  POST_RSVD           = 2'h2;
  localparam logic [1:0]  POST_DIV8           = 2'h3;
  localparam logic [3:0]  N2_BY2              = 4'h2;
  localparam logic [3:0]  N2_BY4              = 4'h4;
  localparam logic [3:0]  N2_BY8              = 4'h8;
  localparam logic [5:0]  PRE_OFFSET          = 6'h02;
  localparam logic [9:0]  FBD_OFFSET          = 10'h002;

  // ****************************************
  // Primary oscillator modes
  // ****************************************
  localparam logic [1:0]  PRI_EC              = 2'h0;
  localparam logic [1:0]  PRI_XT              = 2'h1;
  localparam logic [1:0]  PRI_HS              = 2'h2;
  localparam logic [1:0]  PRI_OFF             = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          SYS_CLK_HZ          = 40_000_000;
  localparam int          INSTR_MAX_HZ        = 40_000_000;
  localparam real         SLOW_RC_KHZ         = 32.768;
  localparam logic [1:0]  CFG_SETTLE          = 2'h3;

  typedef enum logic [2:0] {
    SRC_FAST_RC     = 3'b000,
    SRC_FAST_RC_PLL = 3'b001,
    SRC_PRIMARY     = 3'b010,
    SRC_PRIMARY_PLL = 3'b011,
    SRC_SECONDARY   = 3'b100,
    SRC_SLOW_RC     = 3'b101,
    SRC_FAST_RC_16  = 3'b110,
    SRC_FAST_RC_N   = 3'b111
  } scpc_source_t;

  typedef enum logic [3:0] {
    MODE_FRC      = 4'b0000,
    MODE_FRC_PLL  = 4'b0001,
    MODE_EC       = 4'b0010,
    MODE_XT       = 4'b0011,
    MODE_HS       = 4'b0100,
    MODE_EC_PLL   = 4'b0101,
    MODE_XT_PLL   = 4'b0110,
    MODE_HS_PLL   = 4'b0111,
    MODE_SOSC     = 4'b1000,
    MODE_SLOW_INTERNAL_RC_CLOCK     = 4'b1001,
    MODE_FRC_16   = 4'b1010,
    MODE_FRC_N    = 4'b1011
  } scpc_mode_t;

  typedef enum logic [1:0] {
    POR_WAIT    = 2'b00,
    POR_CAPTURE = 2'b01,
    POR_RUN     = 2'b10
  } scpc_por_t;

endpackage

// file: scpc_ratediv.sv
// Edge-rate divider that passes one of every divisor input pulses.
`timescale 1ns/100ps
module scpc_ratediv #(
  parameter int W = 9
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         in_pulse,
  input  wire logic [W-1:0] divisor,
  output logic              out_pulse
);

  logic [W-1:0] count;
  logic [W-1:0] last_divisor;

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count        <= '0;
      last_divisor <= '0;
      out_pulse    <= 1'b0;
    end else if (divisor != last_divisor) begin
      // A new divisor restarts the count and drops this cycle's pulse.
      last_divisor <= divisor;
      count        <= '0;
      out_pulse    <= 1'b0;
    end else if (in_pulse) begin
      if (count >= divisor - W'(1)) begin
        count     <= '0;
        out_pulse <= 1'b1;
      end else begin
        count     <= count + W'(1);
        out_pulse <= 1'b0;
      end
    end else begin
      out_pulse <= 1'b0;
    end
  end

endmodule // scpc_ratediv

// file: scpc_clock_ctrl.sv
// System clock source selection, PLL rate model and APB register file.
`timescale 1ns/100ps
module scpc_clock_ctrl #(
  parameter int ACC_W = 12
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fast_internal_rc_clock,
  input  wire logic        primary_clock,
  input  wire logic        secondary_low_power_osc,
  input  wire logic        slow_internal_rc_clock,
  input  wire logic [2:0]  initial_source_sel,
  input  wire logic [1:0]  primary_osc_mode_sel,
  output logic             osc_pulse,
  output logic             instr_clk,
  output logic             wdt_ref_clk,
  output logic             clock_failure_monitor_ref,
  output logic      [2:0]  current_source_code,
  output logic      [3:0]  clock_mode,
  output logic      [1:0]  primary_mode,
  output logic             pll_in_use
);

  localparam int NSRC = 4;
  localparam int I_FRC = 0;
  localparam int I_PRI = 1;
  localparam int I_SEC = 2;
  localparam int I_SLOW_INTERNAL_RC_CLOCK = 3;

  logic [NSRC-1:0]  raw_clk;
  logic [NSRC-1:0]  sync1;
  logic [NSRC-1:0]  sync2;
  logic [NSRC-1:0]  sync3;
  logic [NSRC-1:0]  src_edge;
  logic [4:0]       cfg_s1;
  logic [4:0]       cfg_s2;
  scpc_pkg::scpc_por_t por_state;
  logic [1:0]       settle;
  logic [2:0]       fast_rc_postscale_sel;
  logic [1:0]       pll_postscale_sel;
  logic [4:0]       pll_prescale_sel;
  logic [8:0]       pll_feedback_sel;
  logic [5:0]       prescale_factor;
  logic [3:0]       postscale_factor;
  logic [9:0]       feedback_factor;
  logic [9:0]       pll_den;
  logic [9:0]       last_den;
  logic [9:0]       last_fb;
  logic [ACC_W-1:0] pll_acc;
  logic [ACC_W-1:0] pll_sum;
  logic             pll_in_edge;
  logic             pll_pulse;
  logic             frc_n_pulse;
  logic             frc_16_pulse;
  logic             next_osc_pulse;
  logic             apb_setup_done;
  logic             apb_commit;
  logic [31:0]      next_rdata;
  logic             next_err;

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic logic [8:0] frc_divisor(input logic [2:0] code);
    if (code == scpc_pkg::FRCPS_MAX_CODE) begin
      return scpc_pkg::FRC_DIV_MAX;
    end else begin
      return scpc_pkg::FRC_DIV_ONE << code;
    end
  endfunction

  function automatic logic [3:0] post_factor(input logic [1:0] code);
    logic [3:0] f;
    f = scpc_pkg::N2_BY4;
    case (code)
      scpc_pkg::POST_DIV2: f = scpc_pkg::N2_BY2;
      scpc_pkg::POST_DIV4: f = scpc_pkg::N2_BY4;
      scpc_pkg::POST_RSVD: f = scpc_pkg::N2_BY4;
      scpc_pkg::POST_DIV8: f = scpc_pkg::N2_BY8;
      default:             f = scpc_pkg::N2_BY4;
    endcase
    return f;
  endfunction

  function automatic logic [3:0] decode_mode(input logic [2:0] src, input logic [1:0] pri);
    logic [3:0] m;
    m = scpc_pkg::MODE_FRC;
    case (src)
      scpc_pkg::SRC_FAST_RC:     m = scpc_pkg::MODE_FRC;
      scpc_pkg::SRC_FAST_RC_PLL: m = scpc_pkg::MODE_FRC_PLL;
      scpc_pkg::SRC_PRIMARY: begin
        if (pri == scpc_pkg::PRI_EC) begin
          m = scpc_pkg::MODE_EC;
        end else if (pri == scpc_pkg::PRI_XT) begin
          m = scpc_pkg::MODE_XT;
        end else begin
          m = scpc_pkg::MODE_HS;
        end
      end
      scpc_pkg::SRC_PRIMARY_PLL: begin
        if (pri == scpc_pkg::PRI_EC) begin
          m = scpc_pkg::MODE_EC_PLL;
        end else if (pri == scpc_pkg::PRI_XT) begin
          m = scpc_pkg::MODE_XT_PLL;
        end else begin
          m = scpc_pkg::MODE_HS_PLL;
        end
      end
      scpc_pkg::SRC_SECONDARY:   m = scpc_pkg::MODE_SOSC;
      scpc_pkg::SRC_SLOW_RC:     m = scpc_pkg::MODE_SLOW_INTERNAL_RC_CLOCK;
      scpc_pkg::SRC_FAST_RC_16:  m = scpc_pkg::MODE_FRC_16;
      default:                   m = scpc_pkg::MODE_FRC_N;
    endcase
    return m;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  assign raw_clk = {slow_internal_rc_clock, secondary_low_power_osc,
                    primary_clock, fast_internal_rc_clock};

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw_clk[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign src_edge[gi] = sync2[gi] & ~sync3[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cfg_s1 <= {initial_source_sel, primary_osc_mode_sel};
      cfg_s2 <= cfg_s1;
    end
  end

  // ****************************************
  // Power-on source selection
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      por_state           <= scpc_pkg::POR_WAIT;
      settle              <= '0;
      current_source_code <= scpc_pkg::SRC_FAST_RC;
      primary_mode        <= scpc_pkg::PRI_EC;
      clock_mode          <= scpc_pkg::MODE_FRC;
    end else begin
      case (por_state)
        scpc_pkg::POR_WAIT: begin
          settle <= settle + 2'(1);
          if (settle == scpc_pkg::CFG_SETTLE) begin
            por_state <= scpc_pkg::POR_CAPTURE;
          end
        end
        scpc_pkg::POR_CAPTURE: begin
          // A primary source with the oscillator turned off falls back to fast RC.
          if (cfg_s2[4:3] == scpc_pkg::SRC_PRIMARY[2:1]
              && cfg_s2[1:0] == scpc_pkg::PRI_OFF) begin
            current_source_code <= scpc_pkg::SRC_FAST_RC;
            clock_mode          <= scpc_pkg::MODE_FRC;
          end else begin
            current_source_code <= cfg_s2[4:2];
            clock_mode          <= decode_mode(cfg_s2[4:2], cfg_s2[1:0]);
          end
          primary_mode <= cfg_s2[1:0];
          por_state    <= scpc_pkg::POR_RUN;
        end
        scpc_pkg::POR_RUN: begin
          por_state <= scpc_pkg::POR_RUN;
        end
        default: begin
          por_state <= scpc_pkg::POR_WAIT;
        end
      endcase
    end
  end

  // ****************************************
  // PLL rate model
  // ****************************************
  assign prescale_factor  = {1'b0, pll_prescale_sel} + scpc_pkg::PRE_OFFSET;
  assign feedback_factor  = {1'b0, pll_feedback_sel} + scpc_pkg::FBD_OFFSET;
  assign postscale_factor = post_factor(pll_postscale_sel);
  assign pll_den          = 10'(prescale_factor * postscale_factor);
  assign pll_in_edge      = (current_source_code == scpc_pkg::SRC_FAST_RC_PLL)
                            ? src_edge[I_FRC] : src_edge[I_PRI];
  assign pll_sum          = pll_acc + (pll_in_edge ? ACC_W'(feedback_factor) : '0);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pll_acc   <= '0;
      pll_pulse <= 1'b0;
      last_den  <= '0;
      last_fb   <= '0;
    end else if (pll_den != last_den || feedback_factor != last_fb) begin
      last_den  <= pll_den;
      last_fb   <= feedback_factor;
      pll_acc   <= '0;
      pll_pulse <= 1'b0;
    end else if (pll_sum >= ACC_W'(pll_den)) begin
      // Output edges follow input edges times M over N1 times N2.
      pll_acc   <= pll_sum - ACC_W'(pll_den);
      pll_pulse <= 1'b1;
    end else begin
      pll_acc   <= pll_sum;
      pll_pulse <= 1'b0;
    end
  end

  // ****************************************
  // Fast RC postscalers
  // ****************************************
  scpc_ratediv #(.W(9)) u_frc_n (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_pulse  (src_edge[I_FRC]),
    .divisor   (frc_divisor(fast_rc_postscale_sel)),
    .out_pulse (frc_n_pulse)
  );

  scpc_ratediv #(.W(9)) u_frc_16 (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_pulse  (src_edge[I_FRC]),
    .divisor   (scpc_pkg::FRC16_DIV),
    .out_pulse (frc_16_pulse)
  );

  // ****************************************
  // Source multiplexer and instruction clock
  // ****************************************
  always_comb begin
    next_osc_pulse = 1'b0;
    case (current_source_code)
      scpc_pkg::SRC_FAST_RC:     next_osc_pulse = src_edge[I_FRC];
      scpc_pkg::SRC_FAST_RC_PLL: next_osc_pulse = pll_pulse;
      scpc_pkg::SRC_PRIMARY:     next_osc_pulse = src_edge[I_PRI];
      scpc_pkg::SRC_PRIMARY_PLL: next_osc_pulse = pll_pulse;
      scpc_pkg::SRC_SECONDARY:   next_osc_pulse = src_edge[I_SEC];
      scpc_pkg::SRC_SLOW_RC:     next_osc_pulse = src_edge[I_SLOW_INTERNAL_RC_CLOCK];
      scpc_pkg::SRC_FAST_RC_16:  next_osc_pulse = frc_16_pulse;
      default:                   next_osc_pulse = frc_n_pulse;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      osc_pulse  <= 1'b0;
      instr_clk  <= 1'b0;
      pll_in_use <= 1'b0;
    end else begin
      osc_pulse  <= next_osc_pulse;
      // One toggle per oscillator period halves the rate.
      instr_clk  <= instr_clk ^ next_osc_pulse;
      pll_in_use <= (current_source_code == scpc_pkg::SRC_FAST_RC_PLL)
                    || (current_source_code == scpc_pkg::SRC_PRIMARY_PLL);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wdt_ref_clk               <= 1'b0;
      clock_failure_monitor_ref <= 1'b0;
    end else begin
      wdt_ref_clk               <= sync2[I_SLOW_INTERNAL_RC_CLOCK];
      clock_failure_monitor_ref <= sync2[I_SLOW_INTERNAL_RC_CLOCK];
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign apb_setup_done = psel & penable & ~pready;
  assign apb_commit     = psel & penable & pready;

  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (paddr == scpc_pkg::OFS_CLOCK_DIVISOR) begin
      next_rdata[scpc_pkg::FRCPS_LSB +: 3] = fast_rc_postscale_sel;
      next_rdata[scpc_pkg::POST_LSB +: 2]  = pll_postscale_sel;
      next_rdata[scpc_pkg::PRE_LSB +: 5]   = pll_prescale_sel;
    end else if (paddr == scpc_pkg::OFS_PLL_FEEDBACK) begin
      next_rdata[scpc_pkg::FBD_LSB +: 9] = pll_feedback_sel;
    end else if (paddr == scpc_pkg::OFS_OSC_CONTROL) begin
      next_rdata[scpc_pkg::CUR_SRC_LSB +: 3]  = current_source_code;
      next_rdata[scpc_pkg::CLK_MODE_LSB +: 4] = clock_mode;
      next_rdata[scpc_pkg::PRI_MODE_LSB +: 2] = primary_mode;
    end else if (paddr == scpc_pkg::OFS_FACTOR_STATUS) begin
      next_rdata[scpc_pkg::N1_LSB +: 6] = prescale_factor;
      next_rdata[scpc_pkg::N2_LSB +: 4] = postscale_factor;
      next_rdata[scpc_pkg::M_LSB +: 10] = feedback_factor;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_setup_done;
      pslverr <= apb_setup_done & next_err;
      if (apb_setup_done && !pwrite) begin
        prdata <= next_rdata;
      end else if (apb_commit) begin
        prdata <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fast_rc_postscale_sel <= scpc_pkg::FRCPS_RST;
      pll_postscale_sel     <= scpc_pkg::POST_RST;
      pll_prescale_sel      <= scpc_pkg::PRE_RST;
      pll_feedback_sel      <= scpc_pkg::FBD_RST;
    end else if (apb_commit && pwrite) begin
      if (paddr == scpc_pkg::OFS_CLOCK_DIVISOR) begin
        if (pstrb[1]) begin
          fast_rc_postscale_sel <= pwdata[scpc_pkg::FRCPS_LSB +: 3];
        end
        if (pstrb[0]) begin
          pll_postscale_sel <= pwdata[scpc_pkg::POST_LSB +: 2];
          pll_prescale_sel  <= pwdata[scpc_pkg::PRE_LSB +: 5];
        end
      end else if (paddr == scpc_pkg::OFS_PLL_FEEDBACK) begin
        if (pstrb[1]) begin
          pll_feedback_sel[8] <= pwdata[scpc_pkg::FBD_LSB + 8];
        end
        if (pstrb[0]) begin
          pll_feedback_sel[7:0] <= pwdata[scpc_pkg::FBD_LSB +: 8];
        end
      end
    end
  end

endmodule // scpc_clock_ctrl

// file: scpc_clock_ctrl_checker.sv
// Port-level assertions for the system clock and PLL configuration block.
`timescale 1ns/100ps
module scpc_clock_ctrl_checker (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       slow_internal_rc_clock,
  input wire logic       osc_pulse,
  input wire logic       instr_clk,
  input wire logic       wdt_ref_clk,
  input wire logic       clock_failure_monitor_ref,
  input wire logic [2:0] current_source_code,
  input wire logic [3:0] clock_mode,
  input wire logic       pll_in_use
);
  // ****************************************
  // Cycles since reset release
  // ****************************************
  logic [3:0] up_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge sys_clk) begin
    if (!nrst) up_cnt <= 4'h0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  end
  property p_instr_toggle; osc_pulse |-> instr_clk != $past(instr_clk); endproperty
  a_instr_toggle: assert property (p_instr_toggle) else $error("instr clock missed a toggle");
  property p_instr_hold; !osc_pulse |-> $stable(instr_clk); endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("instr clock moved with no pulse");
  property p_pll_flag;
    pll_in_use == ($past(current_source_code) == 3'h1 || $past(current_source_code) == 3'h3);
  endproperty
  a_pll_flag: assert property (p_pll_flag) else $error("pll flag disagrees with source");
  property p_wdt; up_cnt > 4'h5 |-> wdt_ref_clk == $past(slow_internal_rc_clock, 3); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reference not slow rc");
  property p_clock_failure_monitor;
    up_cnt > 4'h5 |-> clock_failure_monitor_ref == $past(slow_internal_rc_clock, 3);
  endproperty
  a_clock_failure_monitor: assert property (p_clock_failure_monitor) else $error("monitor reference not slow rc");
  property p_frcn_mode; current_source_code == 3'h7 |-> clock_mode == 4'hB; endproperty
  a_frcn_mode: assert property (p_frcn_mode) else $error("divide by n mode wrong");
  property p_frc_mode; current_source_code == 3'h0 |-> clock_mode == 4'h0; endproperty
  a_frc_mode: assert property (p_frc_mode) else $error("fast rc mode wrong");
  property p_src_stable; up_cnt > 4'h8 |-> $stable(current_source_code); endproperty
  a_src_stable: assert property (p_src_stable) else $error("source moved after power-on");
  property p_ready; $rose(penable) && psel |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("bus answer not one cycle late");
  c_err: cover property (pready && pslverr);
  c_pll: cover property (pll_in_use && osc_pulse);
  c_frcn: cover property (current_source_code == 3'h7 && osc_pulse);
endmodule // scpc_clock_ctrl_checker

// file: scpc_clock_ctrl_tb_top.sv
// Self-checking bench for the system clock and PLL configuration block.
`timescale 1ns/100ps
module scpc_clock_ctrl_tb_top;
  // ****************************************
  // Stimulus, monitor and verdict
  // ****************************************
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, clock_mode;
  logic        fast_internal_rc_clock, primary_clock, secondary_low_power_osc;
  logic        slow_internal_rc_clock, osc_pulse, instr_clk, wdt_ref_clk;
  logic        clock_failure_monitor_ref, pll_in_use;
  logic [2:0]  initial_source_sel, current_source_code;
  logic [1:0]  primary_osc_mode_sel, primary_mode;
  logic [7:0]  tick;
  logic [32:0] exp_q[$];
  int          fail_count, checks;

  scpc_clock_ctrl scpc_clock_ctrl_i (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .fast_internal_rc_clock, .primary_clock,
    .secondary_low_power_osc, .slow_internal_rc_clock, .initial_source_sel,
    .primary_osc_mode_sel, .osc_pulse, .instr_clk, .wdt_ref_clk, .clock_failure_monitor_ref,
    .current_source_code, .clock_mode, .primary_mode, .pll_in_use);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    tick <= tick + 8'h01;
    primary_clock <= tick[2];
    slow_internal_rc_clock <= tick[4];
    secondary_low_power_osc <= tick[5];
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] want);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(want);
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
    @(posedge sys_clk);
  endtask

  task automatic rst(input logic [2:0] src, input logic [1:0] pm);
    nrst <= 1'b0;
    initial_source_sel <= src;
    primary_osc_mode_sel <= pm;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic frc_run(input int edges, input int want);
    int seen;
    seen = 0;
    for (int k = 0; k < edges * 2 + 2; k++) begin
      if (k < edges * 2) fast_internal_rc_clock <= ~fast_internal_rc_clock;
      repeat (4) begin
        @(posedge sys_clk);
        seen += int'(osc_pulse === 1'b1);
      end
    end
    check(33'(seen), 33'(want));
  endtask

  initial begin
    logic [4:0] pre;
    logic [8:0] fbd;
    logic [1:0] pm;
    logic [3:0] md;
    void'($urandom(37471));
    {nrst, psel, penable, pwrite, paddr, pwdata, fast_internal_rc_clock, tick} = '0;
    pstrb = 4'hF;
    rst(3'h7, 2'h3);
    check(33'({current_source_code, clock_mode}), 33'h7B);
    apb(1'b0, 8'h00, 32'h0, 33'h040);
    apb(1'b0, 8'h04, 32'h0, 33'h030);
    apb(1'b0, 8'h0C, 32'h0, 33'h0032_0402);
    apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) begin
      pre = (i == 0) ? 5'h00 : (i == 3) ? 5'h1F : 5'($urandom_range(31, 0));
      fbd = (i == 0) ? 9'h01E : 9'($urandom_range(511, 0));
      apb(1'b1, 8'h00, {24'h0, 2'(i), 1'b0, pre}, 33'h0);
      apb(1'b1, 8'h04, {23'h0, fbd}, 33'h0);
      apb(1'b0, 8'h00, 32'h0, {25'h0, 2'(i), 1'b0, pre});
      apb(1'b0, 8'h0C, 32'h0, {7'h0, {1'b0, fbd} + 10'h002, 4'h0,
        (i == 3) ? 4'h8 : (i == 0) ? 4'h2 : 4'h4, 2'h0, {1'b0, pre} + 6'h02});
    end
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h00, {21'h0, 3'(c), 8'h40}, 33'h0);
      frc_run((c == 7) ? 256 : 64, (c == 7) ? 1 : (64 >> c));
    end
    for (int s = 0; s < 8; s++) begin
      pm = 2'($urandom_range(2, 0));
      md = (s == 2) ? 4'h2 + pm : (s == 3) ? 4'h5 + pm : (s < 2) ? 4'(s) : 4'(s) + 4'h4;
      rst(3'(s), pm);
      check({pll_in_use, current_source_code, clock_mode, primary_mode},
        {s == 1 || s == 3, 3'(s), md, pm});
      apb(1'b0, 8'h08, 32'h0, {18'h0, 3'(s), 4'h0, md, 2'h0, pm});
      if (s == 1) begin
        apb(1'b1, 8'h00, 32'h0C0, 33'h0);
        apb(1'b1, 8'h04, 32'h026, 33'h0);
        frc_run(64, 160);
      end
      if (s == 0 || s == 6) frc_run(64, (s == 0) ? 64 : 4);
    end
    rst(3'h2, 2'h3);
    check({current_source_code, clock_mode, primary_mode}, 9'h003);
    final_report();
  end
endmodule // scpc_clock_ctrl_tb_top

bind scpc_clock_ctrl scpc_clock_ctrl_checker scpc_clock_ctrl_checker_i (.sys_clk, .nrst,
  .psel, .penable, .pready, .pslverr, .slow_internal_rc_clock, .osc_pulse, .instr_clk,
  .wdt_ref_clk, .clock_failure_monitor_ref, .current_source_code, .clock_mode, .pll_in_use);
